// ### pad_function_mux_and_routing.sv
// Pad function mux, output routing matrix and register port.
// Assumes peripherals and pads are synchronous to clock_in.
`timescale 1ns/1ps
`include "pmx_cfg.svh"
module pad_function_mux_and_routing (
	// Clock and reset
	input wire logic clock_in,
	input wire logic nrst_in,
	// Register port
	input wire logic [11:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// Pads
	input wire logic [39:0] pad_in_in,
	output logic [39:0] pad_out_out,
	output logic [39:0] pad_oe_out,
	output logic [39:0] pad_input_enable_out,
	output logic [39:0] pad_pull_up_out,
	output logic [39:0] pad_pull_down_out,
	output logic [79:0] pad_drive_out,
	// Direct mux peripheral side, six functions per pad
	input wire logic [239:0] func_out_in,
	input wire logic [239:0] func_oe_in,
	output logic [239:0] func_in_out,
	// Matrix peripheral side
	input wire logic [255:0] matrix_out_in,
	input wire logic [255:0] matrix_oe_in,
	output logic [255:0] matrix_in_out
);
	pmx_pkg::pad_cfg_t pad_cfg_ff [`PMX_NUM_PADS];
	logic [39:0] pad_out_ff;
	logic [39:0] pad_oe_ff;
	logic [239:0] func_in_ff;
	logic [255:0] matrix_in_ff;
	logic [31:0] rdata_ff;
	logic [39:0] nxt_pad_out;
	logic [39:0] nxt_pad_oe;
	logic [239:0] nxt_func_in;
	logic [39:0] pad_val_w;
	logic [31:0] nxt_rdata;
	logic [63:0] pad_in_ext;
	logic [5:0] addr_pad_idx;
	logic pad_wr;
	logic route_wr;
	logic [31:0] pad_word;
	logic [31:0] route_word;

	route_if rif ();

	function automatic logic is_input_only_pad(input int p);
		return p >= `PMX_FIRST_IN_ONLY_PAD && p <= `PMX_LAST_IN_ONLY_PAD;
	endfunction

	function automatic logic addr_is_pad(input logic [11:0] a);
		return a <= `PMX_PAD_LAST && a[1:0] == 2'h0;
	endfunction

	function automatic logic addr_is_route(input logic [11:0] a);
		return a[11:10] == `PMX_ROUTE_BASE >> 10 && a[1:0] == 2'h0;
	endfunction

	// Column type of each direct function, same for every pad
	function automatic pmx_pkg::func_type_t func_type(input logic [2:0] f);
		case (f)
			3'h0: return pmx_pkg::bidir_type;
			3'h1: return pmx_pkg::input_held_high_type;
			3'h2: return pmx_pkg::input_held_low_type;
			3'h3: return pmx_pkg::plain_input_type;
			3'h4: return pmx_pkg::bidir_held_high_type;
			3'h5: return pmx_pkg::output_only_type;
			default: return pmx_pkg::plain_input_type;
		endcase
	endfunction

	function automatic logic drives_pad(input pmx_pkg::func_type_t t);
		return t == pmx_pkg::bidir_type || t == pmx_pkg::bidir_held_high_type
			|| t == pmx_pkg::output_only_type;
	endfunction

	// What a function's input sees, selected or not
	function automatic logic func_in_value(input pmx_pkg::func_type_t t,
		input logic sel, input logic v);
		case (t)
			pmx_pkg::plain_input_type: return v;
			pmx_pkg::input_held_high_type: return sel ? v : 1'b1;
			pmx_pkg::input_held_low_type: return sel ? v : 1'b0;
			pmx_pkg::bidir_held_high_type: return sel ? v : 1'b1;
			pmx_pkg::bidir_type: return sel ? v : 1'b0;
			default: return 1'b0;
		endcase
	endfunction

	// Register decode
	assign addr_pad_idx = reg_addr_in[7:2];
	assign pad_wr = reg_wr_in && addr_is_pad(reg_addr_in);
	assign route_wr = reg_wr_in && addr_is_route(reg_addr_in);
	assign pad_in_ext = {24'h0, pad_in_in};
	assign pad_word = {pad_in_ext[addr_pad_idx], 14'h0,
		pad_cfg_ff[addr_pad_idx]};
	always_comb
	begin
		route_word = 32'h0;
		route_word[6:0] = rif.rd_cfg;
		route_word[`PMX_ROUTE_BOTH_BIT] = rif.rd_both;
		route_word[`PMX_ROUTE_LIVE_BIT] = rif.rd_live;
	end
	// Unmapped reads return zero, unmapped writes are dropped
	assign nxt_rdata = !reg_rd_in ? 32'h0 :
		addr_is_pad(reg_addr_in) ? pad_word :
		addr_is_route(reg_addr_in) ? route_word : 32'h0;

	assign rif.wr_en = route_wr;
	assign rif.wr_idx = reg_addr_in[9:2];
	assign rif.wr_cfg = reg_wdata_in[6:0];
	assign rif.rd_idx = reg_addr_in[9:2];
	assign rif.pad_val = pad_val_w;

	periph_input_router u_router (
		.clock_in(clock_in),
		.nrst_in(nrst_in),
		.rif(rif.router)
	);

	for (genvar p = 0; p < `PMX_NUM_PADS; p++)
	begin : g_pad
		pmx_pkg::pad_cfg_t c;
		pmx_pkg::pad_cfg_t wcfg;
		pmx_pkg::func_type_t sel_type;
		logic [7:0] fo;
		logic [7:0] foe;
		assign c = pad_cfg_ff[p];
		assign fo = {2'h0, func_out_in[p*6 +: 6]};
		assign foe = {2'h0, func_oe_in[p*6 +: 6]};
		assign sel_type = func_type(c.fsel);
		assign pad_val_w[p] = pad_in_in[p] & c.input_enable;
		// Matrix overrides the direct mux for the pad's output path
		assign nxt_pad_out[p] = c.matrix_en ? matrix_out_in[c.matrix_idx]
			: fo[c.fsel];
		assign nxt_pad_oe[p] = !is_input_only_pad(p) && (c.matrix_en ?
			matrix_oe_in[c.matrix_idx] :
			drives_pad(sel_type) && foe[c.fsel]);
		for (genvar f = 0; f < `PMX_NUM_FUNCS; f++)
		begin : g_func
			assign nxt_func_in[p*6+f] = func_in_value(func_type(3'(f)),
				c.fsel == 3'(f), pad_val_w[p]);
		end
		// Out-of-range function numbers keep the previous choice
		always_comb
		begin
			wcfg = reg_wdata_in[16:0];
			if (wcfg.fsel > `PMX_FSEL_MAX)
				wcfg.fsel = c.fsel;
			if (is_input_only_pad(p))
			begin
				wcfg.pull_up = 1'b0;
				wcfg.pull_down = 1'b0;
			end
		end
		always_ff @(posedge clock_in)
		begin
			if (!nrst_in)
				pad_cfg_ff[p] <= {1'b0, `PMX_MIDX_RST, `PMX_PULL_RST,
					`PMX_PULL_RST, `PMX_INPUT_ENABLE_RST, `PMX_DRIVE_RST,
					`PMX_FSEL_RST};
			else if (pad_wr && addr_pad_idx == 6'(p))
				pad_cfg_ff[p] <= wcfg;
		end
		assign pad_input_enable_out[p] = c.input_enable;
		assign pad_pull_up_out[p] = c.pull_up;
		assign pad_pull_down_out[p] = c.pull_down;
		assign pad_drive_out[p*2 +: 2] = c.drive;
	end

	always_ff @(posedge clock_in)
	begin
		if (!nrst_in)
		begin
			pad_oe_ff <= 40'h00_0000_0000;
			pad_out_ff <= 40'h00_0000_0000;
			func_in_ff <= 240'h0;
			matrix_in_ff <= 256'h0;
			rdata_ff <= 32'h0000_0000;
		end
		else
		begin
			pad_oe_ff <= nxt_pad_oe;
			pad_out_ff <= nxt_pad_out;
			func_in_ff <= nxt_func_in;
			matrix_in_ff <= rif.routed;
			rdata_ff <= nxt_rdata;
		end
	end

	assign pad_oe_out = pad_oe_ff;
	assign pad_out_out = pad_out_ff;
	assign func_in_out = func_in_ff;
	assign matrix_in_out = matrix_in_ff;
	assign reg_rdata_out = rdata_ff;

	// Checks
	wire [2:0] fsel0 = pad_cfg_ff[0].fsel;
	wire men0 = pad_cfg_ff[0].matrix_en;
	wire [7:0] midx0 = pad_cfg_ff[0].matrix_idx;
	wire ie0 = pad_cfg_ff[0].input_enable;

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!nrst_in);

	sequence drive_write_s;
		reg_wr_in && reg_addr_in == `PMX_PAD_BASE
			&& reg_wdata_in[4:3] == 2'h1;
	endsequence
	sequence drive_readback_s;
		!reg_wr_in && reg_rd_in && reg_addr_in == `PMX_PAD_BASE;
	endsequence
	sequence unassign_inv_s;
		reg_wr_in && reg_addr_in == 12'h474
			&& reg_wdata_in[5:0] == `PMX_PSEL_NONE && reg_wdata_in[6];
	endsequence

	AST_PLAIN_INPUT: assert property (
		1'b1 |=> func_in_out[3] == $past(pad_val_w[0]))
		else $error("plain input lost its pad");
	AST_HELD_HIGH: assert property (
		fsel0 != 3'h1 |=> func_in_out[1])
		else $error("held high input not one");
	AST_HELD_LOW: assert property (
		fsel0 != 3'h2 |=> !func_in_out[2])
		else $error("held low input not zero");
	AST_BIDIR_OWNS_PAD: assert property (
		fsel0 == 3'h0 && !men0 |=> pad_oe_out[0] == $past(func_oe_in[0])
			&& pad_out_out[0] == $past(func_out_in[0]))
		else $error("bidir function lost pad control");
	AST_BIDIR_HELD_HIGH: assert property (
		fsel0 != 3'h4 |=> func_in_out[4])
		else $error("bidir held high input not one");
	AST_RESET_STATE: assert property (
		$rose(nrst_in) |-> pad_oe_out == 40'h0 && fsel0 == `PMX_FSEL_RST
			&& pad_drive_out[1:0] == `PMX_DRIVE_RST && ie0)
		else $error("pad state wrong after reset");
	AST_DRIVE_READBACK: assert property (
		drive_write_s ##1 drive_readback_s |=> reg_rdata_out[4:3] == 2'h1)
		else $error("drive code not stored");
	AST_INPUT_ONLY_PADS: assert property (
		pad_oe_out[39:34] == 6'h0 && pad_pull_up_out[39:34] == 6'h0)
		else $error("input-only pad driven or pulled");
	AST_MATRIX_OUT: assert property (
		men0 && midx0 == 8'h00 |=> pad_out_out[0] == $past(matrix_out_in[0]))
		else $error("matrix output not on pad");
	AST_UNASSIGNED_INVERTED: assert property (
		unassign_inv_s ##1 !reg_wr_in |=> !matrix_in_out[29])
		else $error("inverted default not applied");
	AST_READ_ONE_CYCLE: assert property (
		!reg_rd_in |=> reg_rdata_out == 32'h0)
		else $error("read data outside its cycle");
endmodule // pad_function_mux_and_routing

// ### pad_function_mux_and_routing_tb_top.sv
// Self-checking bench for the pad function mux and input routing.
// Assumes the register port answers reads one cycle after the strobe.
`timescale 1ns/1ps
module pad_function_mux_and_routing_tb_top;
	logic clock_in = 1'h0;
	logic nrst_in = 1'h0;
	logic [11:0] reg_addr_in = 12'h000;
	logic [31:0] reg_wdata_in = 32'h0000_0000;
	logic reg_wr_in = 1'h0;
	logic reg_rd_in = 1'h0;
	logic [31:0] reg_rdata_out;
	logic [39:0] pad_in, pad_out, pad_oe, pad_ie, pad_pu, pad_pd;
	logic [79:0] pad_drive;
	logic [239:0] func_out = '1;
	logic [239:0] func_oe = '1;
	logic [239:0] func_in;
	logic [255:0] mx_out = '0;
	logic [255:0] mx_oe = '0;
	logic [255:0] mx_in;
	logic [39:0] ext_level = 40'h00_0000_0000;
	logic [31:0] rd_val;
	int fail_count = 0;
	int checked = 0;

	always #2.5 clock_in = ~clock_in;

	pad_function_mux_and_routing i_pad_function_mux_and_routing (
		.clock_in(clock_in), .nrst_in(nrst_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .pad_in_in(pad_in),
		.pad_out_out(pad_out), .pad_oe_out(pad_oe),
		.pad_input_enable_out(pad_ie), .pad_pull_up_out(pad_pu),
		.pad_pull_down_out(pad_pd), .pad_drive_out(pad_drive),
		.func_out_in(func_out), .func_oe_in(func_oe), .func_in_out(func_in),
		.matrix_out_in(mx_out), .matrix_oe_in(mx_oe), .matrix_in_out(mx_in)
	);

	pad_partner_model i_pad_partner_model (
		.pad_out_in(pad_out), .pad_oe_in(pad_oe),
		.ext_level_in(ext_level), .pad_in_out(pad_in)
	);

	task automatic chk_word(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_bit(input string name, input logic exp, input logic got);
		chk_word(name, {31'h0000_0000, exp}, {31'h0000_0000, got});
	endtask

	task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock_in);
		reg_wr_in <= 1'h1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clock_in);
		reg_wr_in <= 1'h0;
	endtask

	task automatic reg_read(input logic [11:0] a);
		@(posedge clock_in);
		reg_rd_in <= 1'h1;
		reg_addr_in <= a;
		@(posedge clock_in);
		reg_rd_in <= 1'h0;
		#1 rd_val = reg_rdata_out;
	endtask

	// Outputs lag inputs by one cycle and routing writes by two
	task automatic settle();
		repeat (3) @(posedge clock_in);
		#1;
	endtask

	task automatic print_verdict();
		if (fail_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial
	begin
		#20000;
		fail_count++;
		print_verdict();
	end

	initial
	begin
		// Every function drives during reset; no pad may follow
		repeat (8) @(posedge clock_in);
		#1 chk_word("oe in reset", 32'h0000_0000, pad_oe[31:0]);
		chk_word("drive reset", 32'hAAAA_AAAA, pad_drive[31:0]);
		@(posedge clock_in);
		nrst_in <= 1'h1;
		settle();
		chk_word("oe lo", 32'hFFFF_FFFF, pad_oe[31:0]);
		chk_word("oe hi", 32'h0000_0003, {24'h00_0000, pad_oe[39:32]});
		chk_word("ie", 32'hFFFF_FFFF, pad_ie[31:0]);
		chk_word("pulls", 32'h0000_0000, pad_pu[31:0] | pad_pd[31:0]);
		chk_bit("default 29", 1'h1, mx_in[29]);
		chk_bit("default 0", 1'h0, mx_in[0]);
		reg_read(12'h000);
		chk_word("pad0 reg", 32'h8000_0030, rd_val);
		@(posedge clock_in);
		func_oe <= '0;
		func_out <= '0;
		for (int c = 0; c < 4; c++)
		begin
			reg_write(12'h008, 32'h0000_0020 | (c << 3));
			settle();
			chk_word("drive", c, {30'h0000_0000, pad_drive[5:4]});
		end
		reg_write(12'h008, 32'h0000_0035);
		reg_write(12'h008, 32'h0000_0036);
		reg_read(12'h008);
		chk_word("fsel kept", 32'h0000_0035, rd_val);
		// Write then read with no gap, so the readback check has a case
		@(posedge clock_in);
		reg_wr_in <= 1'h1;
		reg_addr_in <= 12'h000;
		reg_wdata_in <= 32'h0000_0028;
		@(posedge clock_in);
		reg_wr_in <= 1'h0;
		reg_rd_in <= 1'h1;
		@(posedge clock_in);
		reg_rd_in <= 1'h0;
		#1 rd_val = reg_rdata_out;
		chk_word("drive back", 32'h0000_0028, rd_val);
		reg_write(12'h000, 32'h0001_0028);
		mx_out[0] <= 1'h1;
		mx_oe[0] <= 1'h1;
		settle();
		chk_bit("matrix out 0", 1'h1, pad_out[0]);
		chk_bit("matrix oe 0", 1'h1, pad_oe[0]);
		for (int lv = 0; lv < 2; lv++)
		begin
			@(posedge clock_in);
			ext_level[2] <= lv[0];
			settle();
			chk_bit("held high", 1'h1, func_in[13]);
			chk_bit("held low", 1'h0, func_in[14]);
			chk_bit("plain", lv[0], func_in[15]);
			chk_bit("bidir high", 1'h1, func_in[16]);
		end
		// Function 5 on pad 3; function 1 enable must have no say
		reg_write(12'h00C, 32'h0000_0034);
		func_oe[22] <= 1'h1;
		ext_level[3] <= 1'h1;
		settle();
		chk_bit("bidir oe", 1'h1, pad_oe[3]);
		chk_bit("bidir out", 1'h0, pad_out[3]);
		@(posedge clock_in);
		func_oe[22] <= 1'h0;
		func_oe[18] <= 1'h1;
		ext_level[3] <= 1'h0;
		settle();
		chk_bit("bidir float", 1'h0, pad_oe[3]);
		chk_bit("bidir in", 1'h0, func_in[22]);
		reg_write(12'h088, 32'h0000_0070);
		func_oe[204] <= 1'h1;
		settle();
		chk_bit("in-only pull", 1'h0, pad_pu[34]);
		chk_bit("in-only oe", 1'h0, pad_oe[34]);
		reg_write(12'h010, 32'h0001_C830);
		mx_oe[200] <= 1'h1;
		mx_out[200] <= 1'h1;
		settle();
		chk_bit("matrix oe", 1'h1, pad_oe[4]);
		chk_bit("matrix out", 1'h1, pad_out[4]);
		reg_write(12'h414, 32'h0000_0042);
		settle();
		chk_bit("routed inv", 1'h0, mx_in[5]);
		reg_read(12'h414);
		chk_word("route 5", 32'h0000_0142, rd_val);
		reg_read(12'h418);
		chk_word("route 6", 32'h0000_003F, rd_val);
		reg_write(12'h474, 32'h0000_007F);
		settle();
		chk_bit("default inv", 1'h0, mx_in[29]);
		@(posedge clock_in);
		ext_level[39] <= 1'h1;
		for (int m = 40; m < 44; m++)
		begin
			reg_write(12'h400 + 12'(m * 4), 32'h0000_0027);
			settle();
			chk_bit("route to 39", 1'h1, mx_in[m]);
		end
		reg_read(12'h200);
		chk_word("unmapped", 32'h0000_0000, rd_val);
		print_verdict();
	end
endmodule // pad_function_mux_and_routing_tb_top

// ### pad_partner_model.sv
// Board and pad model for the pad function mux.
// Assumes the block's pad outputs are registered, so no loop forms.
`timescale 1ns/1ps
module pad_partner_model (
	// From the block
	input wire logic [39:0] pad_out_in,
	input wire logic [39:0] pad_oe_in,
	// Board level of undriven pads
	input wire logic [39:0] ext_level_in,
	// To the block
	output logic [39:0] pad_in_out
);
	// A driven pad shows the block's level, a released one the board's
	assign pad_in_out = (pad_oe_in & pad_out_in) | (~pad_oe_in & ext_level_in);
endmodule // pad_partner_model

// ### periph_input_router.sv
// Per-peripheral-input pad select and invert table with routing.
// Assumes write strobes arrive already decoded from the register port.
`timescale 1ns/1ps
`include "pmx_cfg.svh"
module periph_input_router (
	// Clock and reset
	input wire logic clock_in,
	input wire logic nrst_in,
	// Control side
	route_if.router rif
);
	pmx_pkg::route_cfg_t cfg_mem [`PMX_NUM_ROUTED];
	logic [255:0] dflt;
	logic [255:0] both;
	logic [63:0] pad_ext;

	assign dflt = `PMX_ROUTE_DEFAULTS;
	assign both = `PMX_ROUTE_BOTH_PATHS;
	assign pad_ext = {24'h0, rif.pad_val};
	assign rif.rd_cfg = cfg_mem[rif.rd_idx];
	assign rif.rd_both = both[rif.rd_idx];
	assign rif.rd_live = rif.routed[rif.rd_idx];

	always_ff @(posedge clock_in)
	begin
		if (!nrst_in)
		begin
			for (int i = 0; i < `PMX_NUM_ROUTED; i++)
				cfg_mem[i] <= {1'b0, `PMX_PSEL_NONE};
		end
		else if (rif.wr_en)
			cfg_mem[rif.wr_idx] <= rif.wr_cfg;
	end

	// Any index may take any pad, management and MII lines included
	for (genvar m = 0; m < `PMX_NUM_ROUTED; m++)
	begin : g_route
		wire assigned = cfg_mem[m].pad_sel < `PMX_PSEL_FIRST_FREE;
		wire base = assigned ? pad_ext[cfg_mem[m].pad_sel] : dflt[m];
		assign rif.routed[m] = base ^ cfg_mem[m].invert;
	end
endmodule // periph_input_router

// ### pmx_cfg.svh
// Constants for the pad function mux and peripheral input routing.
// Assumes one 200 MHz clock and a plain strobe register port.
// Summary of operation
// - Plain input function keeps reading its pad when another function is chosen.
// - Held-high input function sees one when another function is chosen.
// - Held-low input function sees zero when another function is chosen.
// - Bidirectional function's own signals decide read, drive or float per cycle.
// - Bidirectional held-high function sees one when it is not selected.
// - Selected bidirectional function owns the pad input path, and the output path unless the pad's matrix enable is set.
// - Each output pad has a two-bit drive code, 5 to 40 mA, reset code 2.
// - During reset every pad driver is off; enables and pulls take reset values.
// - After reset every pad selects its first function with default enables.
// - After reset the enable of pads 0 to 33 follows the first function's own enable.
// - Matrix connects any routable peripheral output to any of pads 0 to 33.
// - Some peripheral inputs reach pads by both paths; a flag marks them.
// - Peripheral input with no routed pad gets its fixed default constant, inverted when its invert bit is set.
// - Pad select and invert bit per peripheral input set its value, 256 inputs.
// - Management clock, data, carrier sense and collision route to any pad.
// - Function select field holds function number minus one.
// - At most six direct functions per pad.
// - Pads 34 to 39 are input-only: never driven, no pulls.
`ifndef PMX_CFG_SVH
`define PMX_CFG_SVH
`define PMX_NUM_PADS 40
`define PMX_NUM_FUNCS 6
`define PMX_NUM_ROUTED 256
`define PMX_FIRST_IN_ONLY_PAD 34
`define PMX_LAST_IN_ONLY_PAD 39
`define PMX_ADDR_W 12
`define PMX_PAD_BASE 12'h000
`define PMX_PAD_LAST 12'h09C
`define PMX_ROUTE_BASE 12'h400
`define PMX_PAD_LIVE_BIT 31
`define PMX_ROUTE_BOTH_BIT 8
`define PMX_ROUTE_LIVE_BIT 9
`define PMX_FSEL_RST 3'h0
`define PMX_FSEL_MAX 3'h5
`define PMX_DRIVE_RST 2'h2
`define PMX_INPUT_ENABLE_RST 1'h1
`define PMX_PULL_RST 1'h0
`define PMX_MIDX_RST 8'h00
`define PMX_PSEL_NONE 6'h3F
`define PMX_PSEL_FIRST_FREE 6'h28
`define PMX_ROUTE_DEFAULTS 256'h6000_0000
`define PMX_ROUTE_BOTH_PATHS 256'h0006_FF3F
`endif

// ### pmx_pkg.sv
// Types shared by the pad mux and the peripheral input router.
// Assumes field layouts match the constants header.
package pmx_pkg;
	typedef enum logic [5:0] {
		bidir_type = 6'h01,
		input_held_high_type = 6'h02,
		input_held_low_type = 6'h04,
		plain_input_type = 6'h08,
		bidir_held_high_type = 6'h10,
		output_only_type = 6'h20
	} func_type_t;
	// Drive codes 0..3 select about 5, 10, 20, 40 mA
	typedef struct packed {
		logic matrix_en;
		logic [7:0] matrix_idx;
		logic pull_down;
		logic pull_up;
		logic input_enable;
		logic [1:0] drive;
		logic [2:0] fsel;
	} pad_cfg_t;
	typedef struct packed {
		logic invert;
		logic [5:0] pad_sel;
	} route_cfg_t;
endpackage

// ### route_if.sv
// Carrier between the pad mux and the peripheral input router.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface route_if;
	logic wr_en;
	logic [7:0] wr_idx;
	pmx_pkg::route_cfg_t wr_cfg;
	logic [7:0] rd_idx;
	pmx_pkg::route_cfg_t rd_cfg;
	logic rd_both;
	logic rd_live;
	logic [39:0] pad_val;
	logic [255:0] routed;
	modport ctrl (
		output wr_en, wr_idx, wr_cfg, rd_idx, pad_val,
		input rd_cfg, rd_both, rd_live, routed
	);
	modport router (
		input wr_en, wr_idx, wr_cfg, rd_idx, pad_val,
		output rd_cfg, rd_both, rd_live, routed
	);
endinterface // route_if
